//--- txirq_consts.svh
// Register offsets, field positions, widths and reset values
`ifndef TXIRQ_CONSTS_SVH
`define TXIRQ_CONSTS_SVH
`define TXIRQ_ADDR_W 8
`define TXIRQ_OFS_MODE 8'h00
`define TXIRQ_OFS_IRQCFG 8'h04
`define TXIRQ_OFS_FLAGS 8'h08
`define TXIRQ_OFS_FIFO 8'h0C
`define TXIRQ_OFS_STAT 8'h10
`define TXIRQ_OFS_IEN 8'h14
`define TXIRQ_OFS_ICLR 8'h18
`define TXIRQ_OFS_RXEV 8'h1C
`define TXIRQ_OFS_RATE 8'h20
`define TXIRQ_MODE_HI 7
`define TXIRQ_MODE_LO 6
`define TXIRQ_MODE_BUF 5
`define TXIRQ_MODE_TXEN 0
`define TXIRQ_CFG_START_FULL 4
`define TXIRQ_CFG_TXB_SEL 3
`define TXIRQ_CFG_TXA_SEL 2
`define TXIRQ_CFG_RXA_HI 7
`define TXIRQ_CFG_RXA_LO 6
`define TXIRQ_CFG_RXB_HI 5
`define TXIRQ_CFG_RXB_LO 4
`define TXIRQ_CFG_NODE_EN 1
`define TXIRQ_FLG_NEMPTY 0
`define TXIRQ_FLG_FULL 1
`define TXIRQ_FLG_OVR 2
`define TXIRQ_FLG_THRESH 3
`define TXIRQ_FLG_STOP 5
`define TXIRQ_EV_W 4
`define TXIRQ_EV_FULL 0
`define TXIRQ_EV_OVR 1
`define TXIRQ_EV_EMPTY 2
`define TXIRQ_EV_STOP 3
`define TXIRQ_MODE_RST 8'h00
`define TXIRQ_CFG_RST 8'h00
`define TXIRQ_RATE_RST 16'h0007
`define TXIRQ_THR_RST 6'h1F
`endif

//--- txirq_host_model.sv
// Host-side model: continuous transmit data source and receive bit clock
`timescale 1ns/1ns
`default_nettype none
module txirq_host_model (
    input wire logic sys_clk_i,
    input wire logic bit_clk_i,
    input wire logic link_run_i,
    input wire logic send_level_i,
    output logic tx_data_o,
    output logic rx_bit_clock_o
);
    logic bit_clk_q = 1'b0;
    logic data_q = 1'b0;
    logic lclk;
    initial begin
        lclk = 1'b0;
        // Odd offset keeps the link clock out of phase with sys_clk_i
        #7;
        forever #160 lclk = ~lclk;
    end
    // Link clock stands still at 0 outside frames
    assign rx_bit_clock_o = link_run_i & lclk;
    assign tx_data_o = data_q;
    // Data moves on the falling edge so it is settled at the rising one
    always @(posedge sys_clk_i) begin
        bit_clk_q <= bit_clk_i;
        if (bit_clk_q && !bit_clk_i) begin
            data_q <= send_level_i;
        end
    end
endmodule
`default_nettype wire

//--- txirq_pkg.sv
// Types shared by the transmit path and interrupt mapping
package txirq_pkg;
    typedef enum logic [2:0] {
        TXIRQ_DM_CONT = 3'b001,
        TXIRQ_DM_BUF = 3'b010,
        TXIRQ_DM_PKT = 3'b100
    } txirq_dmode_e;
    typedef enum logic [2:0] {
        TXIRQ_SH_IDLE = 3'b001,
        TXIRQ_SH_RUN = 3'b010,
        TXIRQ_SH_LAST = 3'b100
    } txirq_shift_e;
endpackage

//--- txirq_top.sv
// Transmit data path with host interrupt pin mapping
//
// Function
// R1: Mode 00: continuous, bit clock on pin B
// R2: Sample data on bit clock rising edge
// R3: Host paces data by clock under FSK
// R4: Mode bit 5 selects buffered 64-byte FIFO
// R5: FIFO bytes load shifter, bits to modulator
// R6: Start-on-full bit picks first byte or full
// R7: Write when full sets overflow, overwrites
// R8: Writing 1 to overflow clears it and FIFO
// R9: Last byte loaded clears not-empty flag
// R10: Stop flag rises as last bit starts
// R11: Host keeps transmit one more bit period
// R12: Leaving transmit stops at once, drops bits
// R13: Pin B: full or stop, clock in continuous
// R14: Pin A: zero, threshold or not-empty in TX
// R15: Two pins, sources chosen by mode, direction
// R16: Receive pin A source map
// R17: Receive pin B source map
// R18: Mode 10 or 11 packet, 01 buffered
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "txirq_consts.svh"
module txirq_top #(
    parameter int DEPTH = 64,
    parameter int RATE_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`TXIRQ_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic tx_data_i,
    input wire logic rx_bit_clock_i,
    input wire logic tx_mod_fsk_i,
    output logic mod_data_o,
    output logic mod_active_o,
    output logic host_irq_a_o,
    output logic host_irq_b_o,
    output logic irq_o
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

    logic [7:0] mode_r, cfg_r;
    logic [5:0] thr_r;
    logic [RATE_W-1:0] rate_r, div_r;
    logic [7:0] rxev_r;
    logic [`TXIRQ_EV_W-1:0] stat_r, ien_r;
    logic [7:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r, rp_r;
    logic [PW:0] cnt_r;
    logic ovr_r, stop_r, started_r, bclk_r;
    logic [7:0] sh_r;
    logic [2:0] bit_r;
    logic s1_data_r, s2_data_r, s1_rck_r, s2_rck_r;
    txirq_pkg::txirq_shift_e st_r;

    // Data mode decode used by both pin maps
    function automatic txirq_pkg::txirq_dmode_e dmode(input logic [7:0] m);
        if (m[`TXIRQ_MODE_HI]) begin
            return txirq_pkg::TXIRQ_DM_PKT; // [R18]
        end else if (m[`TXIRQ_MODE_LO] || m[`TXIRQ_MODE_BUF]) begin
            return txirq_pkg::TXIRQ_DM_BUF; // [R4] [R18]
        end
        return txirq_pkg::TXIRQ_DM_CONT; // [R1]
    endfunction

    txirq_pkg::txirq_dmode_e dm;
    logic tx_on, buf_tx, wr_acc, bus_en, fifo_wr, ovr_clr;
    logic full, pop, tick, bclk_rise;
    assign dm = dmode(mode_r);
    assign tx_on = mode_r[`TXIRQ_MODE_TXEN];
    assign buf_tx = tx_on && dm != txirq_pkg::TXIRQ_DM_CONT;
    assign bus_en = clk_en_i && psel_i && penable_i;
    assign wr_acc = bus_en && pwrite_i;
    assign fifo_wr = wr_acc && paddr_i == `TXIRQ_OFS_FIFO && buf_tx;
    assign ovr_clr = wr_acc && paddr_i == `TXIRQ_OFS_FLAGS
        && pwdata_i[`TXIRQ_FLG_OVR];
    assign full = cnt_r == DEPTH_C;
    assign pready_o = 1'b1;

    // Pin inputs pass two flops before use
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            {s1_data_r, s2_data_r, s1_rck_r, s2_rck_r} <= 4'h0;
        end else if (clk_en_i) begin
            s1_data_r <= tx_data_i;
            s2_data_r <= s1_data_r;
            s1_rck_r <= rx_bit_clock_i;
            s2_rck_r <= s1_rck_r;
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            mode_r <= `TXIRQ_MODE_RST;
            cfg_r <= `TXIRQ_CFG_RST;
            thr_r <= `TXIRQ_THR_RST;
            rate_r <= RATE_W'(`TXIRQ_RATE_RST);
            ien_r <= '0;
            rxev_r <= 8'h00;
        end else if (wr_acc) begin
            unique case (paddr_i)
                `TXIRQ_OFS_MODE: mode_r <= pwdata_i[7:0];
                `TXIRQ_OFS_IRQCFG: cfg_r <= pwdata_i[7:0];
                `TXIRQ_OFS_IEN: ien_r <= pwdata_i[`TXIRQ_EV_W-1:0];
                `TXIRQ_OFS_RXEV: rxev_r <= pwdata_i[7:0];
                `TXIRQ_OFS_RATE: begin
                    rate_r <= pwdata_i[RATE_W-1:0];
                    thr_r <= pwdata_i[21:16];
                end
                default: ;
            endcase
        end
    end

    // Bit clock divider; runs only in transmit
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            div_r <= '0;
            bclk_r <= 1'b0;
        end else if (clk_en_i) begin
            if (!tx_on) begin
                div_r <= '0;
                bclk_r <= 1'b0;
            end else if (div_r == rate_r) begin
                div_r <= '0;
                bclk_r <= !bclk_r;
            end else begin
                div_r <= div_r + RATE_W'(1);
            end
        end
    end
    assign tick = tx_on && div_r == rate_r;
    assign bclk_rise = tick && !bclk_r;

    // Transmit start gate: first byte or full FIFO
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            started_r <= 1'b0;
        end else if (clk_en_i) begin
            if (!buf_tx || ovr_clr) begin
                started_r <= 1'b0;
            end else if (cfg_r[`TXIRQ_CFG_START_FULL] ? full
                         : cnt_r != '0) begin
                started_r <= 1'b1; // [R6]
            end
        end
    end
    assign pop = buf_tx && started_r && bclk_rise && cnt_r != '0
        && (st_r == txirq_pkg::TXIRQ_SH_IDLE || bit_r == 3'd7);

    // FIFO in flip-flops; full writes overwrite oldest
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (clk_en_i) begin
            if (ovr_clr) begin
                wp_r <= '0; // [R8]
                rp_r <= '0;
                cnt_r <= '0;
            end else begin
                if (fifo_wr) begin
                    wp_r <= PW'((32'(wp_r) + 1) % DEPTH); // [R4]
                end
                if (pop || (fifo_wr && full)) begin
                    rp_r <= PW'((32'(rp_r) + 1) % DEPTH); // [R7]
                end
                if (fifo_wr && !pop && !full) begin
                    cnt_r <= cnt_r + 1'b1;
                end else if (pop && !fifo_wr) begin
                    cnt_r <= cnt_r - 1'b1; // [R9]
                end
            end
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (fifo_wr && clk_en_i) begin
            mem_r[wp_r] <= pwdata_i[7:0];
        end
    end

    // Shift register feeding the modulator, MSB first
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st_r <= txirq_pkg::TXIRQ_SH_IDLE;
            sh_r <= 8'h00;
            bit_r <= 3'd0;
            stop_r <= 1'b0;
        end else if (clk_en_i) begin
            if (!buf_tx) begin
                st_r <= txirq_pkg::TXIRQ_SH_IDLE; // [R12]
                bit_r <= 3'd0;
            end else if (pop) begin
                sh_r <= mem_r[rp_r]; // [R5]
                bit_r <= 3'd0;
                st_r <= txirq_pkg::TXIRQ_SH_RUN;
            end else if (bclk_rise) begin
                unique case (st_r)
                    txirq_pkg::TXIRQ_SH_RUN: begin
                        sh_r <= {sh_r[6:0], 1'b0}; // [R5]
                        bit_r <= bit_r + 3'd1;
                        if (bit_r == 3'd6 && cnt_r == '0) begin
                            st_r <= txirq_pkg::TXIRQ_SH_LAST;
                            stop_r <= 1'b1; // [R10]
                        end
                    end
                    txirq_pkg::TXIRQ_SH_LAST: begin
                        st_r <= txirq_pkg::TXIRQ_SH_IDLE;
                    end
                    default: st_r <= txirq_pkg::TXIRQ_SH_IDLE;
                endcase
            end
            if (fifo_wr) begin
                stop_r <= 1'b0;
            end
        end
    end

    // Overflow flag: set wins over clear
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            ovr_r <= 1'b0;
        end else if (clk_en_i) begin
            if (fifo_wr && full) begin
                ovr_r <= 1'b1; // [R7]
            end else if (ovr_clr) begin
                ovr_r <= 1'b0; // [R8]
            end
        end
    end

    // Modulator drive: continuous mode takes pin data on rise
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            mod_data_o <= 1'b0;
            mod_active_o <= 1'b0;
        end else if (clk_en_i) begin
            if (!tx_on) begin
                mod_data_o <= 1'b0; // [R12]
                mod_active_o <= 1'b0;
            end else if (dm == txirq_pkg::TXIRQ_DM_CONT) begin
                mod_active_o <= 1'b1;
                if (bclk_rise) begin
                    mod_data_o <= s2_data_r; // [R2]
                end
            end else begin
                mod_active_o <= st_r != txirq_pkg::TXIRQ_SH_IDLE;
                mod_data_o <= sh_r[7];
            end
        end
    end

    // Threshold event: level at or below threshold
    logic thr_ev;
    assign thr_ev = cnt_r <= {1'b0, thr_r};
    // Interrupt pin mapping
    logic pin_a, pin_b;
    always_comb begin
        pin_a = 1'b0;
        pin_b = 1'b0;
        if (tx_on) begin
            if (dm == txirq_pkg::TXIRQ_DM_CONT) begin
                pin_b = bclk_r; // [R1] [R13] [R14]
            end else begin
                pin_a = cfg_r[`TXIRQ_CFG_TXA_SEL] ? cnt_r != '0
                    : thr_ev; // [R14] [R9]
                pin_b = cfg_r[`TXIRQ_CFG_TXB_SEL] ? stop_r
                    : full; // [R13]
            end
        end else begin
            unique case (dm)
                txirq_pkg::TXIRQ_DM_CONT: begin
                    pin_a = cfg_r[7:6] == 2'b01 ? rxev_r[0] : rxev_r[1];
                    pin_b = s2_rck_r; // [R16] [R17]
                end
                txirq_pkg::TXIRQ_DM_BUF: begin
                    unique case (cfg_r[7:6])
                        2'b00: pin_a = 1'b0;
                        2'b01: pin_a = rxev_r[2];
                        2'b10: pin_a = cnt_r != '0;
                        2'b11: pin_a = rxev_r[1]; // [R16]
                    endcase
                end
                txirq_pkg::TXIRQ_DM_PKT: begin
                    unique case (cfg_r[7:6])
                        2'b00: pin_a = rxev_r[3];
                        2'b01: pin_a = rxev_r[2];
                        2'b10: pin_a = cnt_r != '0;
                        2'b11: pin_a = cfg_r[`TXIRQ_CFG_NODE_EN]
                            ? rxev_r[4] : rxev_r[1]; // [R16]
                    endcase
                end
            endcase
            if (dm != txirq_pkg::TXIRQ_DM_CONT) begin
                unique case (cfg_r[5:4])
                    2'b00: pin_b = dm == txirq_pkg::TXIRQ_DM_PKT
                        ? rxev_r[5] : 1'b0;
                    2'b01: pin_b = full;
                    2'b10: pin_b = rxev_r[0];
                    2'b11: pin_b = rxev_r[6]; // [R17]
                endcase
            end
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            host_irq_a_o <= 1'b0;
            host_irq_b_o <= 1'b0;
        end else if (clk_en_i) begin
            host_irq_a_o <= pin_a; // [R15]
            host_irq_b_o <= pin_b; // [R15]
        end
    end

    // Sticky events, write-one clear, set wins
    logic [`TXIRQ_EV_W-1:0] ev, clr;
    assign ev = {stop_r, cnt_r == '0, ovr_r, full};
    assign clr = (wr_acc && paddr_i == `TXIRQ_OFS_ICLR)
        ? pwdata_i[`TXIRQ_EV_W-1:0] : '0;
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            stat_r <= '0;
        end else if (clk_en_i) begin
            stat_r <= (stat_r & ~clr) | ev;
        end
    end
    assign irq_o = |(stat_r & ien_r);

    // APB read data; unmapped reads zero with error
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (clk_en_i && psel_i && !penable_i && !pwrite_i) begin
            unique case (paddr_i)
                `TXIRQ_OFS_MODE: prdata_o <= {24'h00_0000, mode_r};
                `TXIRQ_OFS_IRQCFG: prdata_o <= {24'h00_0000, cfg_r};
                `TXIRQ_OFS_FLAGS: prdata_o <= {26'h000_0000, stop_r,
                    1'b0, thr_ev, ovr_r, full, cnt_r != '0};
                `TXIRQ_OFS_STAT: prdata_o <= 32'(stat_r);
                `TXIRQ_OFS_IEN: prdata_o <= 32'(ien_r);
                `TXIRQ_OFS_RXEV: prdata_o <= {24'h00_0000, rxev_r};
                `TXIRQ_OFS_RATE: prdata_o <= {10'h000, thr_r,
                    16'(rate_r)};
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end
    function automatic logic mapped(input logic [`TXIRQ_ADDR_W-1:0] a);
        return a <= `TXIRQ_OFS_RATE && a[1:0] == 2'b00;
    endfunction
    assign pslverr_o = psel_i && penable_i && !mapped(paddr_i);

    chk_ovr_set: assert property (@(posedge sys_clk_i) // [R7]
        disable iff (!nrst_i) clk_en_i && fifo_wr && full |=> ovr_r)
        else $error("overflow not set");
    chk_ovr_clear: assert property (@(posedge sys_clk_i) // [R8]
        disable iff (!nrst_i) clk_en_i && ovr_clr && !(fifo_wr && full)
        |=> !ovr_r && cnt_r == '0) else $error("overflow clear failed");
    chk_cont_pinb: assert property (@(posedge sys_clk_i) // [R1]
        disable iff (!nrst_i)
        clk_en_i && tx_on && dm == txirq_pkg::TXIRQ_DM_CONT
        |=> host_irq_b_o == $past(bclk_r)) else $error("pin B not bit clock");
    chk_cont_pina: assert property (@(posedge sys_clk_i) // [R14]
        disable iff (!nrst_i)
        clk_en_i && tx_on && dm == txirq_pkg::TXIRQ_DM_CONT
        |=> !host_irq_a_o) else $error("pin A not zero");
    chk_stop_off: assert property (@(posedge sys_clk_i) // [R12]
        disable iff (!nrst_i) clk_en_i && !tx_on |=> !mod_active_o)
        else $error("modulator still active");
    chk_fifo_lim: assert property (@(posedge sys_clk_i) // [R4]
        disable iff (!nrst_i) cnt_r <= DEPTH_C)
        else $error("fifo count too high");
    chk_stop_sel: assert property (@(posedge sys_clk_i) // [R13]
        disable iff (!nrst_i)
        clk_en_i && buf_tx && cfg_r[`TXIRQ_CFG_TXB_SEL]
        |=> host_irq_b_o == $past(stop_r)) else $error("pin B not stop");
    chk_pop_load: assert property (@(posedge sys_clk_i) // [R5]
        disable iff (!nrst_i) clk_en_i && pop |=> sh_r == $past(mem_r[rp_r])
        && st_r == txirq_pkg::TXIRQ_SH_RUN) else $error("shifter not loaded");
    cov_full: cover property (@(posedge sys_clk_i) full);
    cov_ovr: cover property (@(posedge sys_clk_i) fifo_wr && full);
    cov_stop: cover property (@(posedge sys_clk_i) $rose(stop_r));
endmodule
`default_nettype wire

//--- txirq_top_tb_top.sv
// Testbench for the transmit path and interrupt pin mapping
`timescale 1ns/1ns
`default_nettype none
`include "txirq_consts.svh"
module txirq_top_tb_top;
    logic sys_clk_i, nrst_i, psel, penable, pwrite, e;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, tx_data, rx_bclk, mod_data, mod_active;
    logic irq_a, irq_b, irq, link_run, send_level;
    int bad_count, n_checks, cnt;
    logic [31:0] tbl [15] = '{32'h0040_0102, 32'h0040_0200, 32'h0000_0202,
        32'h4000_7F00, 32'h4040_0402, 32'h40C0_0202, 32'h4020_0101,
        32'h4030_4001, 32'h8000_0802, 32'h8000_2001, 32'h80C2_1002,
        32'h80C0_0202, 32'h80C2_0200, 32'h8020_0101, 32'hC000_0802};

    txirq_top uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(1'b1),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .tx_data_i(tx_data),
        .rx_bit_clock_i(rx_bclk), .tx_mod_fsk_i(1'b1),
        .mod_data_o(mod_data), .mod_active_o(mod_active),
        .host_irq_a_o(irq_a), .host_irq_b_o(irq_b), .irq_o(irq));
    txirq_host_model host_mdl (.sys_clk_i(sys_clk_i), .bit_clk_i(irq_b),
        .link_run_i(link_run), .send_level_i(send_level),
        .tx_data_o(tx_data), .rx_bit_clock_o(rx_bclk));

    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge sys_clk_i);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk_i);
            penable <= 1'b1;
            // Only the watchdog ends a wait for the slave
            do begin
                @(posedge sys_clk_i);
            end while (pready !== 1'b1);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task count_rise(input int cyc);
        logic p;
        begin
            cnt = 0;
            p = irq_b;
            repeat (cyc) begin
                @(posedge sys_clk_i);
                if (irq_b && !p) cnt++;
                p = irq_b;
            end
        end
    endtask
    task wait_active;
        int n;
        begin
            n = 0;
            while (mod_active !== 1'b1 && n < 2000) begin
                @(posedge sys_clk_i);
                n++;
            end
            if (n >= 2000) bad_count++;
        end
    endtask
    task test_done;
        begin
            $display("checks=%0d mismatches=%0d", n_checks, bad_count);
            if (bad_count == 0 && n_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // Whole run needs about 2000 cycles
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        bad_count++;
        test_done();
    end

    initial begin
        {psel, penable, pwrite, nrst_i, link_run, send_level} = 6'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        bad_count = 0;
        n_checks = 0;
        repeat (20) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        rd(`TXIRQ_OFS_MODE);
        check(q, 32'h0000_0000);
        rd(`TXIRQ_OFS_RATE);
        check(q, 32'h001F_0007);
        rd(8'h3C);
        check({e, q}, {1'b1, 32'h0000_0000});
        // Short bit period keeps the run brief: 8 cycles a bit
        wr(`TXIRQ_OFS_RATE, 32'h001F_0003);
        wr(`TXIRQ_OFS_MODE, 8'h01);
        send_level <= 1'b1;
        repeat (40) @(posedge sys_clk_i);
        check({irq_a, mod_active, mod_data}, 3'b011);
        count_rise(80);
        check(cnt >= 9 && cnt <= 11, 1);
        send_level <= 1'b0;
        repeat (40) @(posedge sys_clk_i);
        check(mod_data, 0);
        wr(`TXIRQ_OFS_MODE, 8'h00);
        link_run <= 1'b1;
        count_rise(160);
        link_run <= 1'b0;
        check(cnt >= 18 && cnt <= 22, 1);
        for (int i = 0; i < 15; i++) begin
            wr(`TXIRQ_OFS_IRQCFG, tbl[i][23:16]);
            wr(`TXIRQ_OFS_RXEV, tbl[i][15:8]);
            wr(`TXIRQ_OFS_MODE, tbl[i][31:24]);
            repeat (4) @(posedge sys_clk_i);
            check({irq_a, irq_b}, tbl[i][1:0]);
        end
        wr(`TXIRQ_OFS_RXEV, 0);
        wr(`TXIRQ_OFS_IRQCFG, 8'h0C);
        wr(`TXIRQ_OFS_MODE, 8'h61);
        wr(`TXIRQ_OFS_FIFO, 8'hA5);
        wait_active();
        for (int i = 0; i < 8; i++) begin
            repeat (i == 0 ? 4 : 8) @(posedge sys_clk_i);
            b = {b[6:0], mod_data};
        end
        check(b, 8'hA5);
        repeat (8) @(posedge sys_clk_i);
        rd(`TXIRQ_OFS_FLAGS);
        check({q[5], q[0]}, 2'b10);
        check({irq_b, irq_a}, 2'b10);
        rd(`TXIRQ_OFS_STAT);
        check(q[3:2], 2'b11);
        // Stay in transmit one more bit period so the last bit goes out
        repeat (8) @(posedge sys_clk_i);
        wr(`TXIRQ_OFS_ICLR, 32'h0000_000F);
        wr(`TXIRQ_OFS_FIFO, 8'h3C);
        wr(`TXIRQ_OFS_FIFO, 8'hC3);
        wait_active();
        repeat (10) @(posedge sys_clk_i);
        wr(`TXIRQ_OFS_MODE, 8'h60);
        repeat (3) @(posedge sys_clk_i);
        check(mod_active, 0);
        wr(`TXIRQ_OFS_FLAGS, 32'h0000_0004);
        // Slow bits hold the first byte in the shifter while we refill
        wr(`TXIRQ_OFS_RATE, 32'h001F_00FF);
        wr(`TXIRQ_OFS_IRQCFG, 8'h10);
        wr(`TXIRQ_OFS_IEN, 32'h0000_0002);
        wr(`TXIRQ_OFS_MODE, 8'h61);
        for (int i = 0; i < 63; i++) wr(`TXIRQ_OFS_FIFO, i);
        // Let bit clock rises pass so an early start would show
        repeat (600) @(posedge sys_clk_i);
        check(mod_active, 0);
        wr(`TXIRQ_OFS_FIFO, 8'h3F);
        // Shifting begins only at the next bit clock rise
        wait_active();
        check(mod_active, 1);
        wr(`TXIRQ_OFS_FIFO, 8'h40);
        wr(`TXIRQ_OFS_FIFO, 8'h41);
        rd(`TXIRQ_OFS_FLAGS);
        check(q[2:1], 2'b11);
        check({irq_a, irq_b, irq}, 3'b011);
        wr(`TXIRQ_OFS_IEN, 0);
        repeat (2) @(posedge sys_clk_i);
        check(irq, 0);
        wr(`TXIRQ_OFS_IEN, 32'h0000_0002);
        repeat (2) @(posedge sys_clk_i);
        check(irq, 1);
        wr(`TXIRQ_OFS_FLAGS, 32'h0000_0004);
        rd(`TXIRQ_OFS_FLAGS);
        check(q[2:0], 3'b000);
        check({irq_a, q[3]}, 2'b11);
        wr(`TXIRQ_OFS_ICLR, 32'h0000_0002);
        repeat (2) @(posedge sys_clk_i);
        check(irq, 0);
        wr(`TXIRQ_OFS_MODE, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
